/* File: cfr_pkg.sv */
// Purpose: Shared constants and types for the clock failure recovery block.
// Assumes: ref_clk runs at 50 MHz; registers sit behind an AXI4-Lite slave.
// Notes:   Every offset, field position, reset value and cycle count is here.
package cfr_pkg;

   // =====================================================================
   // Timing
   // =====================================================================
   localparam int unsigned CLK_PERIOD_NS = 20;
   // The primary clock fails below 1 kHz, so an edge must come within 1 ms.
   localparam int unsigned PRI_MIN_PERIOD_NS = 1000000;
   localparam int unsigned PRI_LIMIT_CYC = PRI_MIN_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned WDOG_LIMIT_CYC = 8004;
   localparam int unsigned CNT_W = 17;

   // =====================================================================
   // Register map
   // =====================================================================
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_MASK = 4'h8;
   localparam logic [3:0] OFS_STATE = 4'hc;

   // Oscillator control fields.
   localparam int unsigned CB_PRI_EN = 0;
   localparam int unsigned CB_WDF_EN = 1;
   localparam int unsigned CB_WDOG_OSC = 2;
   localparam int unsigned CB_IPO = 3;
   localparam int unsigned CB_SEL = 4;
   localparam int unsigned CTRL_W = 6;
   localparam logic [5:0] CTRL_RST = 6'h0c;

   // Event bits of status and mask.
   localparam int unsigned EV_PRI = 0;
   localparam int unsigned EV_WDOG = 1;
   localparam int unsigned EV_W = 2;

   // State register fields.
   localparam int unsigned SB_SEL = 0;
   localparam int unsigned SB_RECOVER = 2;
   localparam int unsigned SB_WDOG_DEAD = 3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SRC_IPO = 2'h0,
      SRC_EXT = 2'h1,
      SRC_WDOG = 2'h2
   } cfr_src_t;

   typedef enum logic [1:0] {
      ST_NORMAL = 2'b01,
      ST_RECOVER = 2'b10
   } cfr_state_t;

endpackage

/* File: cfr_edge_sync.sv */
// Purpose: Brings an oscillator pin into ref_clk and marks its rising edges.
// Assumes: The oscillator is slower than half of ref_clk.
// Notes:   The first stage is read only by the second stage.
module cfr_edge_sync
   import cfr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic oscIn,
   output logic risePulse
);

   logic meta_ff, sync_ff, prev_ff, rise_ff;
   logic nxt_rise;

   // =====================================================================
   // Synchroniser and edge detect
   // =====================================================================
   // Edge seen between the settled stage and its delayed copy.
   always_comb begin
      nxt_rise = sync_ff & ~prev_ff;
   end

   // Two stages before any logic looks at the pin.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         meta_ff <= oscIn;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         rise_ff <= nxt_rise;
      end
   end

   assign risePulse = rise_ff;

endmodule

/* File: cfr_miss_counter.sv */
// Purpose: Counts ref_clk cycles without an oscillator edge and flags a miss.
// Assumes: restart comes from a synchronised edge or a disabled detector.
// Notes:   The counter holds at its limit, so one miss gives one pulse.
module cfr_miss_counter
   import cfr_pkg::*;
#(
   parameter int unsigned W = CNT_W,
   parameter int unsigned LIMIT = WDOG_LIMIT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic restart,
   output logic failPulse
);

   localparam logic [W-1:0] LIM = W'(LIMIT);

   if (LIMIT < 2 || LIMIT >= (2 ** W)) begin : g_bad_limit
      $error("cfr_miss_counter: LIMIT does not fit the counter");
   end

   logic [W-1:0] cnt_ff, nxt_cnt;
   logic fail_ff, nxt_fail;

   // =====================================================================
   // Miss counter
   // =====================================================================
   // Any edge starts a fresh run, so only an unbroken gap fails.
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_fail = 1'b0;
      if (restart) begin
         nxt_cnt = '0;
      end else if (cnt_ff != LIM) begin
         nxt_cnt = cnt_ff + W'(1);
         nxt_fail = (nxt_cnt == LIM);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cnt_ff <= '0;
         fail_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         fail_ff <= nxt_fail;
      end
   end

   assign failPulse = fail_ff;

   a_fail_at_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
      failPulse |-> cnt_ff == LIM && $past(cnt_ff) == LIM - W'(1))
      else $error("miss pulse not at the limit count");
   a_restart_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
      restart |=> cnt_ff == '0 && !failPulse)
      else $error("edge did not clear the miss count");

endmodule

/* File: cfr_clock_recovery.sv */
// Purpose: Watches the primary and watchdog oscillators and recovers the clock.
// Assumes: Oscillator pins are asynchronous to ref_clk and slower than it.
// Notes:   Failure events are nonmaskable pulses plus sticky, maskable status.
module cfr_clock_recovery
   import cfr_pkg::*;
#(
   parameter int unsigned PRI_LIMIT = PRI_LIMIT_CYC,
   parameter int unsigned WDOG_LIMIT = WDOG_LIMIT_CYC
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic priOscIn,
   input wire logic wdogOscIn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [1:0] activeClkSel,
   output logic ipoEnable,
   output logic wdogOscEnable,
   output logic clockFailNmi,
   output logic irq
);

   // =====================================================================
   // Parameter checks
   // =====================================================================
   // Both detectors share one counter width, so each limit must fit below its top value.
   if (PRI_LIMIT < 2 || PRI_LIMIT >= (2 ** CNT_W)) begin : g_bad_pri
      $error("cfr_clock_recovery: PRI_LIMIT does not fit the miss counter");
   end
   if (WDOG_LIMIT < 2 || WDOG_LIMIT >= (2 ** CNT_W)) begin : g_bad_wdog
      $error("cfr_clock_recovery: WDOG_LIMIT does not fit the miss counter");
   end

   // =====================================================================
   // Declarations
   // =====================================================================
   logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
   logic [EV_W-1:0] status_ff, nxt_status;
   logic [EV_W-1:0] mask_ff, nxt_mask;
   logic [EV_W-1:0] evSet, evClr;
   cfr_state_t state_ff, nxt_state;
   logic [1:0] actSel_ff, nxt_actSel;
   logic wdogDead_ff, nxt_wdogDead;
   logic nmi_ff, nxt_nmi;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic rvalid_ff, nxt_rvalid;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wrGo, rdGo, ctrlWrite;
   logic priEdge, wdogEdge;
   logic priRun, wdfRun;
   logic priFail, wdogFail;
   logic recoverCond;
   logic [1:0] selSrc;

   // =====================================================================
   // Oscillator edge capture
   // =====================================================================
   cfr_edge_sync u_pri_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .oscIn(priOscIn),
      .risePulse(priEdge)
   );

   cfr_edge_sync u_wdog_sync (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .oscIn(wdogOscIn),
      .risePulse(wdogEdge)
   );

   // =====================================================================
   // Failure detectors
   // =====================================================================
   // Primary detection stops once the watchdog oscillator has died, since
   // there would be nothing left to recover onto.
   // It also stops while recovery runs: the primary is already known dead.
   assign priRun = ctrl_ff[CB_PRI_EN] & ~wdogDead_ff & (state_ff == ST_NORMAL);
   // A selected or stopped watchdog oscillator cannot be checked here.
   assign wdfRun = ctrl_ff[CB_WDF_EN] & ctrl_ff[CB_WDOG_OSC] & (selSrc != SRC_WDOG) &
                   (state_ff == ST_NORMAL) & ~wdogDead_ff;

   // One 1 ms gap means the clock is below 1 kHz.
   cfr_miss_counter #(
      .W(CNT_W),
      .LIMIT(PRI_LIMIT)
   ) u_pri_miss (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .restart(priEdge | ~priRun),
      .failPulse(priFail)
   );

   cfr_miss_counter #(
      .W(CNT_W),
      .LIMIT(WDOG_LIMIT)
   ) u_wdog_miss (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .restart(wdogEdge | ~wdfRun),
      .failPulse(wdogFail)
   );

   // =====================================================================
   // Clock recovery
   // =====================================================================
   assign selSrc = ctrl_ff[CB_SEL +: 2];
   // Recovery needs a running watchdog oscillator that is not the source.
   assign recoverCond = priFail & ctrl_ff[CB_WDOG_OSC] & (selSrc != SRC_WDOG);

   // Recovery holds until software writes a fresh clock selection.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_NORMAL: begin
            if (recoverCond) begin
               nxt_state = ST_RECOVER;
            end
         end
         ST_RECOVER: begin
            if (ctrlWrite) begin
               nxt_state = ST_NORMAL;
            end
         end
      endcase
      // A watchdog failure never moves the source.
      nxt_actSel = (nxt_state == ST_RECOVER) ? SRC_WDOG : nxt_ctrl[CB_SEL +: 2];
      nxt_wdogDead = wdogDead_ff | wdogFail;
      nxt_nmi = priFail | wdogFail;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_ff <= ST_NORMAL;
         actSel_ff <= SRC_IPO;
         wdogDead_ff <= 1'b0;
         nmi_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         actSel_ff <= nxt_actSel;
         wdogDead_ff <= nxt_wdogDead;
         nmi_ff <= nxt_nmi;
      end
   end

   // =====================================================================
   // AXI4-Lite slave
   // =====================================================================
   // Address and data are taken together; a pending response stalls both.
   assign wrGo = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   assign rdGo = s_axi_arvalid & ~rvalid_ff;
   assign ctrlWrite = wrGo & (s_axi_awaddr == OFS_CTRL) & s_axi_wstrb[0];
   assign evSet = {wdogFail, priFail};
   assign evClr = (wrGo && s_axi_awaddr == OFS_STATUS && s_axi_wstrb[0]) ?
                  s_axi_wdata[EV_W-1:0] : '0;

   // Register writes; only byte lane 0 carries fields.
   // The oscillator enable bit is cleared only by software.
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_mask = mask_ff;
      if (ctrlWrite) begin
         nxt_ctrl = s_axi_wdata[CTRL_W-1:0];
      end
      if (wrGo && s_axi_awaddr == OFS_MASK && s_axi_wstrb[0]) begin
         nxt_mask = s_axi_wdata[EV_W-1:0];
      end
      // A new event wins over a write-one clear in the same cycle.
      nxt_status = (status_ff & ~evClr) | evSet;
   end

   // Write response follows one cycle after the pair is taken.
   always_comb begin
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      if (wrGo) begin
         nxt_bvalid = 1'b1;
         nxt_bresp = (s_axi_awaddr == OFS_STATE || s_axi_awaddr == OFS_CTRL ||
                      s_axi_awaddr == OFS_STATUS || s_axi_awaddr == OFS_MASK) ?
                     RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end
   end

   // Read data is registered; unmapped reads answer zero with SLVERR.
   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (rdGo) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = '0;
         nxt_rresp = RESP_OKAY;
         unique case (s_axi_araddr)
            OFS_CTRL: nxt_rdata[CTRL_W-1:0] = ctrl_ff;
            OFS_STATUS: nxt_rdata[EV_W-1:0] = status_ff;
            OFS_MASK: nxt_rdata[EV_W-1:0] = mask_ff;
            OFS_STATE: begin
               nxt_rdata[SB_SEL +: 2] = actSel_ff;
               nxt_rdata[SB_RECOVER] = (state_ff == ST_RECOVER);
               nxt_rdata[SB_WDOG_DEAD] = wdogDead_ff;
            end
            default: nxt_rresp = RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctrl_ff <= CTRL_RST;
         status_ff <= '0;
         mask_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   // =====================================================================
   // Outputs
   // =====================================================================
   assign s_axi_awready = wrGo;
   assign s_axi_wready = wrGo;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = rdGo;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign activeClkSel = actSel_ff;
   assign ipoEnable = ctrl_ff[CB_IPO];
   assign wdogOscEnable = ctrl_ff[CB_WDOG_OSC];
   assign clockFailNmi = nmi_ff;
   assign irq = |(status_ff & mask_ff);

   // =====================================================================
   // Assertions
   // =====================================================================
   a_recover_switch: assert property (@(posedge ref_clk) disable iff (!nrst)
      recoverCond |=> activeClkSel == SRC_WDOG && state_ff == ST_RECOVER)
      else $error("primary failure did not switch to the watchdog oscillator");
   a_no_switch_off: assert property (@(posedge ref_clk) disable iff (!nrst)
      priFail && !ctrl_ff[CB_WDOG_OSC] && state_ff == ST_NORMAL |=> state_ff == ST_NORMAL)
      else $error("recovery started with the watchdog oscillator off");
   a_nmi_primary: assert property (@(posedge ref_clk) disable iff (!nrst)
      priFail |=> clockFailNmi ##1 !clockFailNmi)
      else $error("primary failure gave no single nmi pulse");
   a_no_switch_self: assert property (@(posedge ref_clk) disable iff (!nrst)
      priFail && selSrc == SRC_WDOG && state_ff == ST_NORMAL |=> state_ff == ST_NORMAL)
      else $error("recovery started while already on the watchdog oscillator");
   a_primary_gap: assert property (@(posedge ref_clk) disable iff (!nrst)
      priFail |-> $past(priRun) && !$past(priEdge))
      else $error("primary failure without an enabled edge gap");
   a_wdog_keeps_src: assert property (@(posedge ref_clk) disable iff (!nrst)
      wdogFail && !ctrlWrite |=> $stable(activeClkSel) && clockFailNmi)
      else $error("watchdog failure moved the clock or gave no nmi");
   a_primary_blind: assert property (@(posedge ref_clk) disable iff (!nrst)
      wdogDead_ff |-> !priRun ##1 !priFail)
      else $error("primary detection still active after watchdog failure");
   a_wdog_gated: assert property (@(posedge ref_clk) disable iff (!nrst)
      selSrc == SRC_WDOG || !ctrl_ff[CB_WDOG_OSC] |-> !wdfRun)
      else $error("watchdog detection ran on a selected or stopped oscillator");
   a_ipo_held: assert property (@(posedge ref_clk) disable iff (!nrst)
      ipoEnable && !ctrlWrite |=> ipoEnable)
      else $error("oscillator enable dropped without a software write");
   a_status_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
      evSet[EV_PRI] |=> status_ff[EV_PRI])
      else $error("event did not set its status bit");
   a_wdog_status: assert property (@(posedge ref_clk) disable iff (!nrst)
      evSet[EV_WDOG] |=> status_ff[EV_WDOG])
      else $error("watchdog event did not set its status bit");
   a_recover_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      state_ff == ST_RECOVER && !ctrlWrite |=> state_ff == ST_RECOVER && activeClkSel == SRC_WDOG)
      else $error("recovery left without a software write");
   a_dead_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
      wdogDead_ff |=> wdogDead_ff)
      else $error("watchdog failure record dropped before reset");
   // Each answer comes one cycle after its request and stands until the master takes it.
   a_write_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
      wrGo |=> s_axi_bvalid)
      else $error("write taken without a response");
   a_read_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
      rdGo |=> s_axi_rvalid)
      else $error("read taken without data");
   a_bvalid_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before it was taken");
   a_rvalid_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed before it was taken");

   c_recovery: cover property (@(posedge ref_clk) disable iff (!nrst)
      recoverCond ##1 state_ff == ST_RECOVER);
   c_wdog_fail: cover property (@(posedge ref_clk) disable iff (!nrst)
      wdogFail ##1 clockFailNmi);
   c_irq: cover property (@(posedge ref_clk) disable iff (!nrst)
      $rose(irq));
   c_back_to_normal: cover property (@(posedge ref_clk) disable iff (!nrst)
      state_ff == ST_RECOVER ##1 state_ff == ST_NORMAL);

endmodule

/* File: cfr_clock_recovery_tb_top.sv */
// Purpose: Self-checking bench for the clock failure recovery block.
// Assumes: Short failure limits; AXI4-Lite register access; seed fixed.
// Notes:   Oscillator pins are made by the bench from cycle counters.
module cfr_clock_recovery_tb_top
   import cfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PL = 40;
   localparam int WL = 30;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %0t value %0h expected %0h", $time, (g), (e)); end end
   logic ref_clk, nrst, priOscIn, wdogOscIn;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, activeClkSel;
   logic ipoEnable, wdogOscEnable, clockFailNmi, irq;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0, priHalf = 3, wdogHalf = 3, priCnt = 0, wdogCnt = 0, priRise = 0, wdogRise = 0;
   logic [31:0] v, c;

   cfr_clock_recovery #(.PRI_LIMIT(PL), .WDOG_LIMIT(WL)) DUT (.ref_clk(ref_clk), .nrst(nrst),
      .priOscIn(priOscIn), .wdogOscIn(wdogOscIn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .activeClkSel(activeClkSel),
      .ipoEnable(ipoEnable), .wdogOscEnable(wdogOscEnable), .clockFailNmi(clockFailNmi), .irq(irq));

   // =====================================================================
   // Clock and oscillator pins
   // =====================================================================
   // A half period of zero stops a pin where it stands, as a dead crystal would.
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (priHalf != 0) begin
         priCnt <= (priCnt >= priHalf - 1) ? 0 : priCnt + 1;
         if (priCnt >= priHalf - 1) priOscIn <= ~priOscIn;
         if (priCnt >= priHalf - 1 && !priOscIn) priRise <= cyc;
      end
      if (wdogHalf != 0) begin
         wdogCnt <= (wdogCnt >= wdogHalf - 1) ? 0 : wdogCnt + 1;
         if (wdogCnt >= wdogHalf - 1) wdogOscIn <= ~wdogOscIn;
         if (wdogCnt >= wdogHalf - 1 && !wdogOscIn) wdogRise <= cyc;
      end
   end

   // =====================================================================
   // Bus and helper tasks
   // =====================================================================
   function automatic logic [31:0] ctl(bit p, bit w, bit we, bit ip, logic [1:0] s);
      return {26'h0, s, ip, we, w, p};
   endfunction
   // Address and data are offered together; the slave takes both at one edge.
   // Waits are open; only the bench watchdog ends a hung handshake.
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (awready !== 1'b1) @(posedge ref_clk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge ref_clk);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (arready !== 1'b1) @(posedge ref_clk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge ref_clk);
      rready <= 1'b0;
      `CHK(rresp, er)
      `CHK(rdata, e)
   endtask
   task automatic quiet(input int n);
      bit seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (clockFailNmi !== 1'b0) seen = 1'b1;
      end
      `CHK(seen, 1'b0)
   endtask
   // The failure must land between the limit and ten cycles past it after the last rising edge of the pin.
   task automatic fail(input int lim, input bit wd);
      int i, r;
      // Step past the edge so that a rise launched there is already recorded.
      #1;
      r = wd ? wdogRise : priRise;
      for (i = 0; i < lim + 60 && clockFailNmi !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      `CHK((cyc - r >= lim) && (cyc - r <= lim + 10), 1'b1)
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic rst(input int n);
      @(posedge ref_clk);
      nrst <= 1'b0;
      priHalf = 3;
      wdogHalf = 3;
      repeat (n) @(posedge ref_clk);
      nrst <= 1'b1;
   endtask
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // =====================================================================
   // Watchdog
   // =====================================================================
   initial begin
      repeat (30000) @(posedge ref_clk);
      miscompares++;
      print_verdict();
   end

   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      {nrst, priOscIn, wdogOscIn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      void'($urandom(20563));
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      // Reset state.
      rd(OFS_CTRL, 32'h0000000c);
      rd(OFS_STATUS, 32'h0);
      rd(OFS_MASK, 32'h0);
      rd(OFS_STATE, 32'h0);
      `CHK({ipoEnable, wdogOscEnable, activeClkSel, irq}, 5'h18)
      // Misaligned offsets are refused with an error and read back as zero.
      wr(4'h6, 32'h3, RESP_SLVERR);
      rd(4'h6, 32'h0, RESP_SLVERR);
      // Random mask and control values, detectors held off.
      repeat (8) begin
         v = $urandom;
         c = $urandom & 32'h0000001c;
         wr(OFS_MASK, v);
         rd(OFS_MASK, v & 32'h3);
         wr(OFS_CTRL, c);
         rd(OFS_CTRL, c);
         repeat (2) @(posedge ref_clk);
         `CHK({activeClkSel, ipoEnable, wdogOscEnable}, {c[5:4], c[3], c[2]})
         `CHK(irq, 1'b0)
      end
      // Primary failure with recovery, then status, mask and clear.
      rst(4);
      wr(OFS_CTRL, ctl(0, 0, 1, 1, SRC_EXT));
      wr(OFS_CTRL, ctl(1, 0, 1, 1, SRC_EXT));
      quiet(150);
      priHalf = 0;
      fail(PL, 0);
      `CHK(activeClkSel, SRC_WDOG)
      rd(OFS_STATUS, 32'h1);
      `CHK(irq, 1'b0)
      wr(OFS_MASK, 32'h1);
      `CHK(irq, 1'b1)
      wr(OFS_STATUS, 32'h1);
      @(posedge ref_clk);
      `CHK(irq, 1'b0)
      wr(OFS_CTRL, ctl(0, 0, 1, 1, SRC_IPO));
      repeat (2) @(posedge ref_clk);
      `CHK(activeClkSel, SRC_IPO)
      // No switch while the watchdog oscillator is off.
      rst(4);
      wr(OFS_CTRL, ctl(0, 0, 0, 1, SRC_EXT));
      wr(OFS_CTRL, ctl(1, 0, 0, 1, SRC_EXT));
      priHalf = 0;
      fail(PL, 0);
      `CHK(activeClkSel, SRC_EXT)
      // No switch while the watchdog oscillator already drives the clock.
      rst(4);
      wr(OFS_CTRL, ctl(0, 0, 1, 1, SRC_WDOG));
      wr(OFS_CTRL, ctl(1, 0, 1, 1, SRC_WDOG));
      priHalf = 0;
      fail(PL, 0);
      rd(OFS_STATE, 32'h2);
      // Watchdog oscillator failure, slow but live edges first.
      rst(4);
      wr(OFS_CTRL, ctl(0, 0, 1, 1, SRC_EXT));
      wr(OFS_CTRL, ctl(1, 1, 1, 1, SRC_EXT));
      wdogHalf = 13;
      quiet(300);
      wdogHalf = 0;
      fail(WL, 1);
      `CHK(activeClkSel, SRC_EXT)
      rd(OFS_STATUS, 32'h2);
      priHalf = 0;
      quiet(3 * PL);
      rd(OFS_STATUS, 32'h2);
      // Watchdog detection stays silent when its oscillator is off or selected.
      rst(4);
      wdogHalf = 0;
      // A very slow external clock runs with its primary detector left off.
      priHalf = 30;
      wr(OFS_CTRL, ctl(0, 0, 0, 1, SRC_EXT));
      wr(OFS_CTRL, ctl(0, 1, 0, 1, SRC_EXT));
      quiet(3 * WL);
      wr(OFS_CTRL, ctl(0, 0, 1, 1, SRC_WDOG));
      wr(OFS_CTRL, ctl(0, 1, 1, 1, SRC_WDOG));
      quiet(3 * WL);
      print_verdict();
   end
endmodule
